// >>> third_io_port_pin_pkg.sv
/*
  Package for the third-port pin function logic: register byte offsets,
  field positions, reset values and timing counts.
  Assumes a 32-bit APB slave where each register takes one aligned word.
*/
package third_io_port_pin_pkg;

  localparam int unsigned  PIN_COUNT     = 6;
  localparam int unsigned  CLK_HZ        = 50_000_000;
  localparam int unsigned  STATUS_BITS   = 4;

  // Register byte offsets.
  localparam logic [7:0]   OFS_PORT_DATA = 8'h00;
  localparam logic [7:0]   OFS_PORT_DIR  = 8'h04;
  localparam logic [7:0]   OFS_TIMER_CTL = 8'h08;
  localparam logic [7:0]   OFS_CLKO_CTL  = 8'h0c;
  localparam logic [7:0]   OFS_RSTO_CTL  = 8'h10;
  localparam logic [7:0]   OFS_IRQ_STAT  = 8'h14;
  localparam logic [7:0]   OFS_IRQ_MASK  = 8'h18;
  localparam logic [7:0]   OFS_PIN_LEVEL = 8'h1c;

  // Field positions.
  localparam int unsigned  TCTL_A_MODE   = 0;
  localparam int unsigned  TCTL_B_MODE   = 2;
  localparam int unsigned  CLKO_TA_EN    = 0;
  localparam int unsigned  CLKO_TB_EN    = 2;
  localparam int unsigned  CLKO_MC_EN    = 4;
  localparam int unsigned  CLKO_DIV_LO   = 5;
  localparam int unsigned  RSTO_LEVEL    = 0;
  localparam int unsigned  RSTO_RELEASE  = 1;
  localparam int unsigned  LEVEL_STRAP   = 8;

  // Status bit positions.
  localparam int unsigned  ST_IRQ_A      = 0;
  localparam int unsigned  ST_IRQ_B      = 1;
  localparam int unsigned  ST_IRQ_C      = 2;
  localparam int unsigned  ST_IRQ_D      = 3;

  // Pin positions.
  localparam int unsigned  PIN_TB_CLKO   = 0;
  localparam int unsigned  PIN_TB_CNT    = 1;
  localparam int unsigned  PIN_IRQ_A     = 2;
  localparam int unsigned  PIN_IRQ_B     = 3;
  localparam int unsigned  PIN_SHARED    = 4;
  localparam int unsigned  PIN_TA_CLKO   = 5;

  // Master clock divider select codes.
  localparam logic [1:0]   DIV_BY_1      = 2'h0;
  localparam logic [1:0]   DIV_BY_2      = 2'h1;
  localparam logic [1:0]   DIV_BY_4      = 2'h2;

  // Reset values.
  localparam logic [5:0]   RST_PORT_DATA = 6'h3f;
  localparam logic [5:0]   RST_PORT_DIR  = 6'h00;
  localparam logic [2:0]   RST_TIMER_CTL = 3'h0;
  localparam logic [6:0]   RST_CLKO_CTL  = 7'h00;
  localparam logic [1:0]   RST_RSTO_CTL  = 2'h0;
  localparam logic [3:0]   RST_IRQ_STAT  = 4'h0;
  localparam logic [3:0]   RST_IRQ_MASK  = 4'h0;

  // Reset pin must stay high for two machine cycles; one clock each.
  localparam int unsigned  RST_MIN_MCYC  = 2;
  localparam int unsigned  CLK_PER_MCYC  = 1;
  localparam logic [1:0]   RST_MIN_CLK   = 2'(RST_MIN_MCYC * CLK_PER_MCYC);

endpackage

// >>> pin_edge_detect.sv
/*
  One pin sampler: registers a pin level and flags rising and falling edges.
  Assumes the pin input is already synchronous to pclk.
*/
module pin_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level_r,
  output logic      rise,
  output logic      fall
);

  logic             prev_r;
  logic             primed_r;

  // The first sample after reset loads both stages from the pin. A pin that
  // is low at release, such as the reset-state output, then gives no false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r  <= 1'b1;
      prev_r   <= 1'b1;
      primed_r <= 1'b0;
    end else begin
      level_r  <= pin_in;
      prev_r   <= primed_r ? level_r : pin_in;
      primed_r <= 1'b1;
    end
  end

  assign rise = level_r & ~prev_r;
  assign fall = ~level_r & prev_r;

endmodule // pin_edge_detect

// >>> third_io_port_pin_function_logic.sv
/*
  Pin function logic for the six shared third-port pins: general I/O,
  external interrupt edge detection with sticky status, power-down wake
  request, timer count inputs, timer and master clock outputs, reset input
  and reset-state output, with an APB register slave.
  Assumes pin inputs synchronous to pclk, a strap level that is stable at
  reset release, and timer clock outputs supplied by the timer block.
*/
// Added by the designer: the APB slave port and the placing of the registers.
// Overview of operation
// RL1: Edge mode one: irq a on falling edge only.
// RL2: Edge mode zero: irq a on both edges.
// RL3: Edge mode one: irq b on falling edge only.
// RL4: Edge mode zero: irq b on both edges.
// RL5: Qualifying irq b edge requests power-down wake.
// RL6: Irq c falling edge only, also wakes.
// RL7: Irq d falling edge only, also wakes.
// RL8: External reset held high two machine cycles.
// RL9: Reset-state pin low in reset, software raises.
// RL10: Master clock out divided by one, two, four.
// RL11: Control bit zero routes timer a clock out.
// RL12: Control bit routes timer b clock out.
// RL13: Pin bit one feeds timer b count.
// RL14: Shared reset pin feeds timer a count.
// RL15: Pins default to general purpose I/O bits.
// RL16: Reset input only when strap enables it.
// RL17: Edges set sticky pending flags until cleared.
// RL18: Alternate outputs off fall back to I/O.
module third_io_port_pin_function_logic (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  pin_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe_n,
  input  wire logic        reset_pin_strap,
  input  wire logic        timer_a_clock_out,
  input  wire logic        timer_b_clock_out,
  output logic             timer_a_count_in,
  output logic             timer_b_count_in,
  output logic             pin_reset_req,
  output logic             wake_req,
  output logic      [3:0]  ext_irq_pending,
  output logic             irq
);

  logic [5:0]  port_data_r;
  logic [5:0]  port_dir_r;
  logic [2:0]  timer_control_reg_r;
  logic [6:0]  clock_output_control_reg_r;
  logic [1:0]  reset_out_ctl_r;
  logic [3:0]  irq_status_r;
  logic [3:0]  irq_status_nxt;
  logic [3:0]  irq_mask_r;
  logic [3:0]  irq_set;
  logic [5:0]  level;
  logic [5:0]  rise;
  logic [5:0]  fall;
  logic        strap_done_r;
  logic        reset_pin_en_r;
  logic [1:0]  rst_high_cnt_r;
  logic [1:0]  div_cnt_r;
  logic        master_clock_out;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic        ext_irq_a;
  logic        ext_irq_b;
  logic        ext_irq_c;
  logic        ext_irq_d;

  // Qualifies a pin edge for an interrupt with selectable edge mode.
  function automatic logic edge_qualify(input logic fall_only, input logic r,
                                        input logic f);
    edge_qualify = f | (r & ~fall_only);
  endfunction

  // Address decode shared by the write enable and the error answer.
  function automatic logic addr_mapped(input logic [7:0] a);
    unique case (a)
      third_io_port_pin_pkg::OFS_PORT_DATA,
      third_io_port_pin_pkg::OFS_PORT_DIR,
      third_io_port_pin_pkg::OFS_TIMER_CTL,
      third_io_port_pin_pkg::OFS_CLKO_CTL,
      third_io_port_pin_pkg::OFS_RSTO_CTL,
      third_io_port_pin_pkg::OFS_IRQ_STAT,
      third_io_port_pin_pkg::OFS_IRQ_MASK,
      third_io_port_pin_pkg::OFS_PIN_LEVEL: addr_mapped = 1'b1;
      default:                      addr_mapped = 1'b0;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < third_io_port_pin_pkg::PIN_COUNT; g++) begin : g_pin
      pin_edge_detect u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (pin_in[g]),
        .level_r (level[g]),
        .rise    (rise[g]),
        .fall    (fall[g])
      );
    end
  endgenerate

  // APB slave: zero wait states, error on an unmapped offset.
  assign addr_ok  = addr_mapped(paddr);
  assign wr_en    = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        third_io_port_pin_pkg::OFS_PORT_DATA: prdata <= {26'h0, port_data_r};
        third_io_port_pin_pkg::OFS_PORT_DIR:  prdata <= {26'h0, port_dir_r};
        third_io_port_pin_pkg::OFS_TIMER_CTL: prdata <= {29'h0, timer_control_reg_r};
        third_io_port_pin_pkg::OFS_CLKO_CTL:  prdata <= {25'h0, clock_output_control_reg_r};
        third_io_port_pin_pkg::OFS_RSTO_CTL:  prdata <= {30'h0, reset_out_ctl_r};
        third_io_port_pin_pkg::OFS_IRQ_STAT:  prdata <= {28'h0, irq_status_r};
        third_io_port_pin_pkg::OFS_IRQ_MASK:  prdata <= {28'h0, irq_mask_r};
        third_io_port_pin_pkg::OFS_PIN_LEVEL: prdata <= {23'h0, reset_pin_en_r, 2'h0, level};
        default:                      prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers; alternate output enables clear on reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_r                <= third_io_port_pin_pkg::RST_PORT_DATA;
      port_dir_r                 <= third_io_port_pin_pkg::RST_PORT_DIR;
      timer_control_reg_r        <= third_io_port_pin_pkg::RST_TIMER_CTL;
      clock_output_control_reg_r <= third_io_port_pin_pkg::RST_CLKO_CTL; // RL18
      reset_out_ctl_r            <= third_io_port_pin_pkg::RST_RSTO_CTL; // RL9
      irq_mask_r                 <= third_io_port_pin_pkg::RST_IRQ_MASK;
    end else if (wr_en) begin
      unique case (paddr)
        third_io_port_pin_pkg::OFS_PORT_DATA: port_data_r <= pwdata[5:0];
        third_io_port_pin_pkg::OFS_PORT_DIR:  port_dir_r <= pwdata[5:0];
        third_io_port_pin_pkg::OFS_TIMER_CTL: begin
          timer_control_reg_r <= {pwdata[third_io_port_pin_pkg::TCTL_B_MODE], 1'b0,
                                  pwdata[third_io_port_pin_pkg::TCTL_A_MODE]};
        end
        third_io_port_pin_pkg::OFS_CLKO_CTL:  clock_output_control_reg_r <= pwdata[6:0];
        third_io_port_pin_pkg::OFS_RSTO_CTL:  reset_out_ctl_r <= pwdata[1:0]; // RL9
        third_io_port_pin_pkg::OFS_IRQ_MASK:  irq_mask_r <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // Interrupt edge qualification.
  assign ext_irq_a = edge_qualify(timer_control_reg_r[third_io_port_pin_pkg::TCTL_A_MODE],
                                  rise[third_io_port_pin_pkg::PIN_IRQ_A],
                                  fall[third_io_port_pin_pkg::PIN_IRQ_A]); // RL1 RL2
  assign ext_irq_b = edge_qualify(timer_control_reg_r[third_io_port_pin_pkg::TCTL_B_MODE],
                                  rise[third_io_port_pin_pkg::PIN_IRQ_B],
                                  fall[third_io_port_pin_pkg::PIN_IRQ_B]); // RL3 RL4
  assign ext_irq_c = fall[third_io_port_pin_pkg::PIN_SHARED]; // RL6
  assign ext_irq_d = fall[third_io_port_pin_pkg::PIN_TA_CLKO]; // RL7
  assign irq_set   = {ext_irq_d, ext_irq_c, ext_irq_b, ext_irq_a};

  // A new edge in the cycle of a write-one clear keeps the flag set.
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_en && paddr == third_io_port_pin_pkg::OFS_IRQ_STAT) begin
      irq_status_nxt = irq_status_r & ~pwdata[3:0];
    end
    irq_status_nxt = irq_status_nxt | irq_set; // RL17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= third_io_port_pin_pkg::RST_IRQ_STAT;
    end else begin
      irq_status_r <= irq_status_nxt; // RL17
    end
  end

  assign ext_irq_pending = irq_status_r;
  assign irq             = |(irq_status_r & irq_mask_r);

  // Wake is requested regardless of the mask, since the core is stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= ext_irq_b | ext_irq_c | ext_irq_d; // RL5 RL6 RL7
    end
  end

  // The strap is caught on the first clock after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_r   <= 1'b0;
      reset_pin_en_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r   <= 1'b1;
      reset_pin_en_r <= reset_pin_strap; // RL16
    end
  end

  // Shorter high pulses are treated as noise and never reset the device.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_high_cnt_r <= 2'h0;
    end else if (!reset_pin_en_r || !level[third_io_port_pin_pkg::PIN_SHARED]) begin
      rst_high_cnt_r <= 2'h0;
    end else if (rst_high_cnt_r != third_io_port_pin_pkg::RST_MIN_CLK) begin
      rst_high_cnt_r <= rst_high_cnt_r + 2'h1; // RL8
    end
  end

  assign pin_reset_req = reset_pin_en_r && (rst_high_cnt_r == third_io_port_pin_pkg::RST_MIN_CLK);

  // Master clock divider; the divide-by-one path passes pclk itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 2'h0;
    end else begin
      div_cnt_r <= div_cnt_r + 2'h1; // RL10
    end
  end

  always_comb begin
    unique case (clock_output_control_reg_r[third_io_port_pin_pkg::CLKO_DIV_LO +: 2])
      third_io_port_pin_pkg::DIV_BY_2: master_clock_out = div_cnt_r[0]; // RL10
      third_io_port_pin_pkg::DIV_BY_4: master_clock_out = div_cnt_r[1]; // RL10
      default:                 master_clock_out = pclk; // RL10
    endcase
  end

  // Count inputs follow the sampled pins; the timers pick their own mode.
  assign timer_b_count_in = level[third_io_port_pin_pkg::PIN_TB_CNT]; // RL13
  assign timer_a_count_in = level[third_io_port_pin_pkg::PIN_SHARED]; // RL14

  // Pin output selection; every pin falls back to its port bit.
  always_comb begin
    pin_out  = port_data_r; // RL15
    pin_oe_n = ~port_dir_r; // RL15
    if (clock_output_control_reg_r[third_io_port_pin_pkg::CLKO_TB_EN]) begin
      pin_out[third_io_port_pin_pkg::PIN_TB_CLKO]  = timer_b_clock_out; // RL12
      pin_oe_n[third_io_port_pin_pkg::PIN_TB_CLKO] = 1'b0; // RL12
    end
    if (!reset_out_ctl_r[third_io_port_pin_pkg::RSTO_RELEASE]) begin
      pin_out[third_io_port_pin_pkg::PIN_IRQ_B]  = reset_out_ctl_r[third_io_port_pin_pkg::RSTO_LEVEL]; // RL9
      pin_oe_n[third_io_port_pin_pkg::PIN_IRQ_B] = 1'b0; // RL9
    end
    if (reset_pin_en_r) begin
      pin_oe_n[third_io_port_pin_pkg::PIN_SHARED] = 1'b1; // RL16
    end else if (clock_output_control_reg_r[third_io_port_pin_pkg::CLKO_MC_EN]) begin
      pin_out[third_io_port_pin_pkg::PIN_SHARED]  = master_clock_out; // RL10
      pin_oe_n[third_io_port_pin_pkg::PIN_SHARED] = 1'b0; // RL10
    end
    if (clock_output_control_reg_r[third_io_port_pin_pkg::CLKO_TA_EN]) begin
      pin_out[third_io_port_pin_pkg::PIN_TA_CLKO]  = timer_a_clock_out; // RL11
      pin_oe_n[third_io_port_pin_pkg::PIN_TA_CLKO] = 1'b0; // RL11
    end
  end

  sequence shared_high_two;
    (reset_pin_en_r && level[third_io_port_pin_pkg::PIN_SHARED]) [*2];
  endsequence

  sequence div_two_on;
    clock_output_control_reg_r[6:5] == 2'h1 && !reset_pin_en_r &&
      clock_output_control_reg_r[4];
  endsequence

  sequence irq_b_qualified;
    fall[third_io_port_pin_pkg::PIN_IRQ_B] ||
      (rise[third_io_port_pin_pkg::PIN_IRQ_B] &&
       !timer_control_reg_r[third_io_port_pin_pkg::TCTL_B_MODE]);
  endsequence

  a_fall_only_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    timer_control_reg_r[0] && rise[2] && !irq_status_r[0] && !fall[2]
      |=> !irq_status_r[0])
    else $error("irq a set on rising edge in falling mode");

  both_edges_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    !timer_control_reg_r[0] && rise[2] |=> irq_status_r[0])
    else $error("irq a missed a rising edge in both-edge mode");

  fall_only_b_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    timer_control_reg_r[2] && rise[3] && !irq_status_r[1]
      |=> !irq_status_r[1])
    else $error("irq b set on rising edge in falling mode");

  both_edges_b_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    !timer_control_reg_r[2] && (rise[3] || fall[3]) |=> irq_status_r[1])
    else $error("irq b missed an edge in both-edge mode");

  wake_from_b_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    irq_b_qualified |=> wake_req)
    else $error("no wake after qualifying irq b edge");

  irq_c_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    fall[4] |=> wake_req && irq_status_r[2])
    else $error("irq c falling edge lost");

  irq_d_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    $rose(irq_status_r[3]) |-> $past(fall[5]) && wake_req)
    else $error("irq d set without a falling edge");

  pin_reset_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    shared_high_two |=> pin_reset_req)
    else $error("reset request missing after two high cycles");

  reset_out_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    !reset_out_ctl_r[1] && !reset_out_ctl_r[0] |-> !pin_out[3] && !pin_oe_n[3])
    else $error("reset-state pin not driven low");

  div_two_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    div_two_on ##1 div_two_on |-> pin_out[4] != $past(pin_out[4]))
    else $error("master clock out not toggling at half rate");

  timer_b_route_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    clock_output_control_reg_r[2] |-> pin_out[0] == timer_b_clock_out && !pin_oe_n[0])
    else $error("timer b clock not on its pin");

  reset_pin_input_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    reset_pin_en_r |-> pin_oe_n[4])
    else $error("reset input pin is being driven");

  timer_a_route_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    clock_output_control_reg_r[0] |-> pin_out[5] == timer_a_clock_out && !pin_oe_n[5])
    else $error("timer a clock not on its pin");

  gpio_default_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    clock_output_control_reg_r[0] == 1'b0 |-> pin_out[5] == port_data_r[5] &&
      pin_oe_n[5] == !port_dir_r[5])
    else $error("pin five not following its port bit");

  pending_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    irq_status_r[0] && !(wr_en && paddr == 8'h14) |=> irq_status_r[0])
    else $error("pending flag dropped without a clear");

endmodule // third_io_port_pin_function_logic

// >>> pin_board_model.sv
/*
  Board model for the six third-port pins: resolves each line from the
  device drive and the board drive.
  Assumes the bench sets the board values right after a rising edge.
*/
module pin_board_model (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  input  wire logic [5:0] drive_val,
  input  wire logic [5:0] drive_en,
  output logic      [5:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A line that nobody drives rests at the pull-up level, never at its last value.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) begin
        pin_level[i] = pin_out[i];
      end else if (drive_en[i]) begin
        pin_level[i] = drive_val[i];
      end else begin
        pin_level[i] = 1'b1;
      end
    end
  end
endmodule // pin_board_model

// >>> testbench.sv
/*
  Self-checking bench for the third-port pin function logic.
  Assumes a zero-wait APB slave and pins sampled on pclk.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, strap, ta_clk, tb_clk;
  logic        pready, pslverr, err, ta_cnt, tb_cnt, rreq, wake, irq, pv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d, dir;
  logic [5:0]  pin_in, pin_out, pin_oe_n, bval, ben;
  logic [3:0]  pend;
  int          fails, total_checks, wakes, n, m, k, w0;

  third_io_port_pin_function_logic dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .reset_pin_strap(strap), .timer_a_clock_out(ta_clk),
    .timer_b_clock_out(tb_clk), .timer_a_count_in(ta_cnt), .timer_b_count_in(tb_cnt),
    .pin_reset_req(rreq), .wake_req(wake), .ext_irq_pending(pend), .irq(irq));
  pin_board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive_val(bval),
    .drive_en(ben), .pin_level(pin_in));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) if (wake === 1'b1) wakes++;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // Called right after a rising edge; leaves one idle cycle so strobes never rise twice.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int c;
    c = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("mismatch pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic rst(input logic s);
    presetn <= 1'b0; strap <= s;
    repeat (3) @(posedge pclk);
    chk("reset oe", 32'h37, 32'(pin_oe_n));
    chk("reset out", 32'h37, 32'(pin_out));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    $display("mismatch watchdog expected done seen timeout");
    conclude();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; strap = 1'b0; ta_clk = 1'b0; tb_clk = 1'b0; bval = 6'h3f; ben = 6'h3f;
    void'($urandom(8));
    rst(1'b0);
    for (n = 0; n < 7; n++) rdc("reset reg", 8'(n * 4), n == 0 ? 32'h3f : 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    wr(8'h10, 32'h1);
    chk("rsto high", 32'h0, {30'h0, pin_oe_n[3], ~pin_out[3]});
    wr(8'h10, 32'h2);
    for (m = 0; m < 2; m++) for (k = 0; k < 2; k++) begin
      wr(8'h08, 32'(m) << (k ? 2 : 0));
      wr(8'h14, 32'hf);
      w0 = wakes;
      bval[2 + k] <= 1'b0;
      wait_n(4);
      rdc("fall status", 8'h14, 32'h1 << k);
      wr(8'h14, 32'hf);
      bval[2 + k] <= 1'b1;
      wait_n(4);
      rdc("rise status", 8'h14, m ? 32'h0 : 32'h1 << k);
      chk("wake ab", 32'(k ? (m ? 1 : 2) : 0), 32'(wakes - w0));
    end
    for (k = 0; k < 2; k++) begin
      wr(8'h14, 32'hf);
      w0 = wakes;
      bval[4 + k] <= 1'b0;
      wait_n(4);
      rdc("fall cd", 8'h14, 32'h4 << k);
      bval[4 + k] <= 1'b1;
      wait_n(4);
      rdc("rise cd", 8'h14, 32'h4 << k);
      chk("wake cd", 32'h1, 32'(wakes - w0));
    end
    chk("pending d", 32'h8, 32'(pend));
    for (n = 0; n < 4; n++) begin
      d = $urandom;
      wr(8'h18, d);
      chk("irq", {31'h0, d[3]}, {31'h0, irq});
    end
    wr(8'h18, 32'hf);
    wr(8'h14, 32'hf);
    chk("irq clear", 32'h0, {31'h0, irq});
    chk("pending clear", 32'h0, 32'(pend));
    for (n = 0; n < 8; n++) begin
      d = $urandom;
      dir = $urandom;
      bval <= 6'($urandom);
      wr(8'h00, d);
      wr(8'h04, dir);
      wait_n(2);
      chk("gpio oe", {26'h0, ~dir[5:0]}, 32'(pin_oe_n));
      chk("gpio out", 32'(dir[5:0] & d[5:0]), 32'(dir[5:0] & pin_out));
      rdc("levels", 8'h1c, 32'((dir[5:0] & d[5:0]) | (~dir[5:0] & bval)));
      chk("count b", 32'(pin_in[1]), 32'(tb_cnt));
      chk("count a", 32'(pin_in[4]), 32'(ta_cnt));
      chk("no reset req", 32'h0, 32'(rreq));
    end
    wr(8'h0c, 32'h5);
    for (n = 0; n < 8; n++) begin
      @(posedge pclk);
      ta_clk <= 1'($urandom);
      tb_clk <= 1'($urandom);
      @(negedge pclk);
      chk("ta clko", {30'h0, 1'b0, ta_clk}, {30'h0, pin_oe_n[5], pin_out[5]});
      chk("tb clko", {30'h0, 1'b0, tb_clk}, {30'h0, pin_oe_n[0], pin_out[0]});
    end
    @(posedge pclk);
    wr(8'h0c, 32'h0);
    chk("fallback", 32'({d[5], d[0]}), 32'({pin_out[5], pin_out[0]}));
    for (m = 1; m < 3; m++) begin
      wr(8'h0c, 32'h10 | (32'(m) << 5));
      k = 0;
      pv = pin_out[4];
      repeat (16) begin
        @(posedge pclk);
        if (pin_out[4] === 1'b1 && pv === 1'b0) k++;
        pv = pin_out[4];
      end
      chk("mclk rises", m == 1 ? 32'h8 : 32'h4, 32'(k));
    end
    wr(8'h0c, 32'h10);
    @(negedge pclk);
    #1;
    chk("mclk div1 low", 32'h0, 32'(pin_out[4]));
    @(posedge pclk);
    #1;
    chk("mclk div1 high", 32'h1, 32'(pin_out[4]));
    @(posedge pclk);
    bval[4] <= 1'b0;
    rst(1'b1);
    apb(1'b0, 8'h1c, 32'h0);
    chk("strap", 32'h1, 32'(rd[8]));
    bval[4] <= 1'b1;
    @(posedge pclk);
    bval[4] <= 1'b0;
    repeat (4) begin
      @(posedge pclk);
      chk("short pulse", 32'h0, 32'(rreq));
    end
    bval[4] <= 1'b1;
    wait_n(4);
    chk("reset req", 32'h1, 32'(rreq));
    bval[4] <= 1'b0;
    wait_n(3);
    chk("reset req drop", 32'h0, 32'(rreq));
    conclude();
  end
endmodule // testbench
